// file: rtl/dspwm_timer.sv
/*
 * Dual-slope PWM timer: phase correct and phase and frequency correct
 * waveform generation on a 16-bit up/down counter, two compare channels,
 * registers on an APB slave.
 * Assumes a prescaler outside that supplies timer_tick_in as a one-cycle
 * enable, and a port pad that takes value and enable from this block.
 */
`timescale 1ns/1ps
`include "dspwm_cfg.svh"

module dspwm_timer
   import dspwm_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic mclk_in, // i/o clock, 50 MHz
   input wire logic rst_n_in, // asynchronous reset, active low
   input wire logic timer_tick_in, // prescaled tick, counter step enable
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb enable
   input wire logic pwrite_in, // apb direction, high for write
   input wire logic [11:0] paddr_in, // apb byte address
   input wire logic [31:0] pwdata_in, // apb write data
   output logic [31:0] prdata_out, // apb read data
   output logic pready_out, // apb ready
   output logic pslverr_out, // apb error on unmapped address
   output logic waveform_output_a_out, // channel a pin value
   output logic waveform_output_a_oe_out, // channel a pin enable
   output logic waveform_output_b_out, // channel b pin value
   output logic waveform_output_b_oe_out, // channel b pin enable
   output logic overflow_flag_out, // sticky overflow flag
   output logic capture_flag_out // sticky capture-as-top flag
);

   ////////////////////////////////////////////////////////////////////////
   // state

   dspwm_ctrl_t ctrl;
   dspwm_flags_t flags;
   dspwm_slope_t slope;
   logic [CNT_W-1:0] count_value;
   logic [CNT_W-1:0] compare_a_value;
   logic [CNT_W-1:0] compare_b_value;
   logic [CNT_W-1:0] buffer_a;
   logic [CNT_W-1:0] buffer_b;
   logic [CNT_W-1:0] capture_top_value;
   logic waveform_output_a;
   logic waveform_output_b;

   ////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic is_phase_correct(input logic [3:0] ws);
      is_phase_correct = (ws == `DSPWM_WS_PC8) || (ws == `DSPWM_WS_PC9) ||
         (ws == `DSPWM_WS_PC10) || (ws == `DSPWM_WS_PC_CAP) ||
         (ws == `DSPWM_WS_PC_CMPA);
   endfunction

   function automatic logic is_freq_correct(input logic [3:0] ws);
      is_freq_correct = (ws == `DSPWM_WS_PFC_CAP) || (ws == `DSPWM_WS_PFC_CMPA);
   endfunction

   // fixed top for codes 1..3, zero when top is programmable
   function automatic logic [CNT_W-1:0] fixed_top(input logic [3:0] ws);
      logic [CNT_W-1:0] t;
      t = '0;
      unique case (ws)
         `DSPWM_WS_PC8:
            t = CNT_W'(`DSPWM_TOP_8BIT);
         `DSPWM_WS_PC9:
            t = CNT_W'(`DSPWM_TOP_9BIT);
         `DSPWM_WS_PC10:
            t = CNT_W'(`DSPWM_TOP_10BIT);
         default:
            t = '0;
      endcase
      fixed_top = t;
   endfunction

   // masks bits above a fixed resolution
   function automatic logic [CNT_W-1:0] mask_compare(input logic [3:0] ws,
                                                      input logic [CNT_W-1:0] v);
      logic [CNT_W-1:0] t;
      t = fixed_top(ws);
      mask_compare = (t != '0) ? (v & t) : v;
   endfunction

   function automatic logic top_from_cmpa(input logic [3:0] ws);
      top_from_cmpa = (ws == `DSPWM_WS_PC_CMPA) || (ws == `DSPWM_WS_PFC_CMPA);
   endfunction

   function automatic logic top_from_capture(input logic [3:0] ws);
      top_from_capture = (ws == `DSPWM_WS_PC_CAP) || (ws == `DSPWM_WS_PFC_CAP);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // top, slope and events

   logic pwm_mode;
   logic pc_mode;
   logic pfc_mode;
   logic [CNT_W-1:0] top_value;
   logic at_top;
   logic at_bottom;
   logic step;
   logic eff_up;
   logic match_a;
   logic match_b;
   logic [CNT_W-1:0] next_count;
   dspwm_slope_t next_slope;

   assign pc_mode = is_phase_correct(ctrl.wsel);
   assign pfc_mode = is_freq_correct(ctrl.wsel);
   assign pwm_mode = pc_mode || pfc_mode;
   assign step = timer_tick_in && pwm_mode;

   // programmable top, any value up to maximum
   always_comb
   begin
      if (top_from_cmpa(ctrl.wsel))
      begin
         top_value = compare_a_value;
      end
      else if (top_from_capture(ctrl.wsel))
      begin
         top_value = capture_top_value;
      end
      else
      begin
         top_value = fixed_top(ctrl.wsel);
      end
   end

   assign at_top = (count_value == top_value);
   assign at_bottom = (count_value == CNT_W'(`DSPWM_BOTTOM));

   // the slope a match belongs to: zero counts as rising, top as falling,
   // which makes compare zero stay low and compare top stay high
   // at these extreme compare values in non-inverting action
   assign eff_up = at_bottom ? 1'b1 : (at_top ? 1'b0 : (slope == DSPWM_SLOPE_UP));

   // a compare above top is never reached by the counter
   assign match_a = (count_value == compare_a_value);
   assign match_b = (count_value == compare_b_value);

   // up to top, down to bottom, repeating
   // top stands one tick, then the count turns
   always_comb
   begin
      next_count = count_value;
      next_slope = slope;
      if (at_top && (slope == DSPWM_SLOPE_UP))
      begin
         next_count = count_value - CNT_W'(1);
         next_slope = DSPWM_SLOPE_DOWN;
      end
      else if (at_bottom && (slope == DSPWM_SLOPE_DOWN))
      begin
         next_count = count_value + CNT_W'(1);
         next_slope = DSPWM_SLOPE_UP;
      end
      else if (slope == DSPWM_SLOPE_UP)
      begin
         next_count = count_value + CNT_W'(1);
      end
      else
      begin
         next_count = count_value - CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   logic wr_en;
   logic rd_setup;
   logic addr_ok;

   assign wr_en = psel_in && penable_in && pwrite_in && addr_ok;
   assign rd_setup = psel_in && !penable_in && !pwrite_in;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !addr_ok;

   always_comb
   begin
      unique case (paddr_in)
         `DSPWM_OFS_CONTROL, `DSPWM_OFS_COUNT, `DSPWM_OFS_COMPARE_A,
         `DSPWM_OFS_COMPARE_B, `DSPWM_OFS_CAPTURE_TOP, `DSPWM_OFS_FLAGS,
         `DSPWM_OFS_STATUS:
            addr_ok = 1'b1;
         default:
            addr_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // control register

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl <= dspwm_ctrl_t'(10'h000);
      end
      else if (wr_en && (paddr_in == `DSPWM_OFS_CONTROL))
      begin
         ctrl <= dspwm_ctrl_t'(pwdata_in[`DSPWM_CTL_DIR_B_BIT:`DSPWM_CTL_WSEL_LSB]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter and slope

   // steps only on a tick, all on the i/o clock
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_value <= '0;
         slope <= DSPWM_SLOPE_UP;
      end
      else if (wr_en && (paddr_in == `DSPWM_OFS_COUNT))
      begin
         // a software write wins over a tick in the same cycle
         count_value <= pwdata_in[CNT_W-1:0];
      end
      else if (step)
      begin
         count_value <= next_count;
         slope <= next_slope;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare buffers and active compares

   logic load_compares;

   // loads at top in phase correct: rising slope sees old top, falling slope new; loads at bottom in frequency correct
   assign load_compares = step && ((pc_mode && at_top) || (pfc_mode && at_bottom));

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         buffer_a <= '0;
         buffer_b <= '0;
      end
      else
      begin
         if (wr_en && (paddr_in == `DSPWM_OFS_COMPARE_A))
         begin
            buffer_a <= mask_compare(ctrl.wsel, pwdata_in[CNT_W-1:0]);
         end
         if (wr_en && (paddr_in == `DSPWM_OFS_COMPARE_B))
         begin
            buffer_b <= mask_compare(ctrl.wsel, pwdata_in[CNT_W-1:0]);
         end
      end
   end

   // outside the dual-slope modes the buffers pass straight through
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         compare_a_value <= '0;
         compare_b_value <= '0;
      end
      else if (load_compares || !pwm_mode)
      begin
         compare_a_value <= buffer_a;
         compare_b_value <= buffer_b;
      end
   end

   // capture register has no buffer; a low write can be overshot
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         capture_top_value <= CNT_W'(`DSPWM_RST_CAPTURE_TOP);
      end
      else if (wr_en && (paddr_in == `DSPWM_OFS_CAPTURE_TOP))
      begin
         capture_top_value <= pwdata_in[CNT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags

   dspwm_flags_t set_flags;
   dspwm_flags_t clr_flags;
   logic top_flag_tick;

   // top flag at top, with the load only in phase correct
   // top flag when top is reached
   assign top_flag_tick = step && at_top && (slope == DSPWM_SLOPE_UP);

   always_comb
   begin
      set_flags = '0;
      // overflow at bottom in phase correct
      // overflow with the load at bottom in frequency correct
      set_flags.overflow = step && at_bottom && (slope == DSPWM_SLOPE_DOWN);
      // match flags on each matching tick
      set_flags.match_a = step && match_a;
      set_flags.match_b = step && match_b;
      set_flags.capture = top_flag_tick && top_from_capture(ctrl.wsel);
      if (top_flag_tick && top_from_cmpa(ctrl.wsel))
      begin
         set_flags.match_a = 1'b1;
      end
   end

   always_comb
   begin
      clr_flags = '0;
      if (wr_en && (paddr_in == `DSPWM_OFS_FLAGS))
      begin
         clr_flags.overflow = pwdata_in[`DSPWM_FLG_OVERFLOW_BIT];
         clr_flags.match_a = pwdata_in[`DSPWM_FLG_MATCH_A_BIT];
         clr_flags.match_b = pwdata_in[`DSPWM_FLG_MATCH_B_BIT];
         clr_flags.capture = pwdata_in[`DSPWM_FLG_CAPTURE_BIT];
      end
   end

   // set wins over a clear in the same cycle
   // flags clear at reset
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flags <= '0;
      end
      else
      begin
         flags <= set_flags | (flags & ~clr_flags);
      end
   end

   assign overflow_flag_out = flags.overflow;
   assign capture_flag_out = flags.capture;

   ////////////////////////////////////////////////////////////////////////
   // waveform outputs

   // clear rising, set falling; three inverts
   // toggle when compare a is top
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         waveform_output_a <= 1'b0;
      end
      else if (step && match_a)
      begin
         unique case (ctrl.act_a)
            `DSPWM_ACT_NONINV:
               waveform_output_a <= !eff_up;
            `DSPWM_ACT_INV:
               waveform_output_a <= eff_up;
            `DSPWM_ACT_TOGGLE:
               waveform_output_a <= top_from_cmpa(ctrl.wsel) ^ waveform_output_a;
            `DSPWM_ACT_OFF:
               waveform_output_a <= waveform_output_a;
         endcase
      end
   end

   // channel b has no toggle action
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         waveform_output_b <= 1'b0;
      end
      else if (step && match_b)
      begin
         unique case (ctrl.act_b)
            `DSPWM_ACT_NONINV:
               waveform_output_b <= !eff_up;
            `DSPWM_ACT_INV:
               waveform_output_b <= eff_up;
            `DSPWM_ACT_TOGGLE, `DSPWM_ACT_OFF:
               waveform_output_b <= waveform_output_b;
         endcase
      end
   end

   // pad enabled only by its direction bit
   assign waveform_output_a_out = waveform_output_a;
   assign waveform_output_a_oe_out = ctrl.dir_a;
   assign waveform_output_b_out = waveform_output_b;
   assign waveform_output_b_oe_out = ctrl.dir_b;

   ////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase

   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = `DSPWM_RST_WORD;
      unique case (paddr_in)
         `DSPWM_OFS_CONTROL:
            next_rdata[`DSPWM_CTL_DIR_B_BIT:`DSPWM_CTL_WSEL_LSB] = ctrl;
         `DSPWM_OFS_COUNT:
            next_rdata[CNT_W-1:0] = count_value;
         `DSPWM_OFS_COMPARE_A:
            next_rdata[CNT_W-1:0] = buffer_a;
         `DSPWM_OFS_COMPARE_B:
            next_rdata[CNT_W-1:0] = buffer_b;
         `DSPWM_OFS_CAPTURE_TOP:
            next_rdata[CNT_W-1:0] = capture_top_value;
         `DSPWM_OFS_FLAGS:
            next_rdata[`DSPWM_FLG_CAPTURE_BIT:`DSPWM_FLG_OVERFLOW_BIT] = flags;
         `DSPWM_OFS_STATUS:
         begin
            next_rdata[`DSPWM_STS_DOWN_BIT] = (slope == DSPWM_SLOPE_DOWN);
            next_rdata[`DSPWM_STS_WAVE_A_BIT] = waveform_output_a;
            next_rdata[`DSPWM_STS_WAVE_B_BIT] = waveform_output_b;
         end
         default:
            next_rdata = `DSPWM_RST_WORD;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prdata_out <= `DSPWM_RST_WORD;
      end
      else if (rd_setup)
      begin
         prdata_out <= next_rdata;
      end
   end

endmodule

// file: shared/dspwm_cfg.svh
/*
 * Constants of the dual-slope PWM timer: register offsets, field positions,
 * reset values and fixed top values.
 * Assumes inclusion by bare name from the package and from the design.
 */
`ifndef DSPWM_CFG_SVH
`define DSPWM_CFG_SVH

// register byte offsets on the APB
`define DSPWM_OFS_CONTROL 12'h000
`define DSPWM_OFS_COUNT 12'h004
`define DSPWM_OFS_COMPARE_A 12'h008
`define DSPWM_OFS_COMPARE_B 12'h00C
`define DSPWM_OFS_CAPTURE_TOP 12'h010
`define DSPWM_OFS_FLAGS 12'h014
`define DSPWM_OFS_STATUS 12'h018

// control register field positions
`define DSPWM_CTL_WSEL_LSB 0
`define DSPWM_CTL_ACT_A_LSB 4
`define DSPWM_CTL_ACT_B_LSB 6
`define DSPWM_CTL_DIR_A_BIT 8
`define DSPWM_CTL_DIR_B_BIT 9

// flag register bit positions, write one to clear
`define DSPWM_FLG_OVERFLOW_BIT 0
`define DSPWM_FLG_MATCH_A_BIT 1
`define DSPWM_FLG_MATCH_B_BIT 2
`define DSPWM_FLG_CAPTURE_BIT 3

// status register bit positions
`define DSPWM_STS_DOWN_BIT 0
`define DSPWM_STS_WAVE_A_BIT 1
`define DSPWM_STS_WAVE_B_BIT 2

// waveform select codes
`define DSPWM_WS_PC8 4'h1
`define DSPWM_WS_PC9 4'h2
`define DSPWM_WS_PC10 4'h3
`define DSPWM_WS_PFC_CAP 4'h8
`define DSPWM_WS_PFC_CMPA 4'h9
`define DSPWM_WS_PC_CAP 4'hA
`define DSPWM_WS_PC_CMPA 4'hB

// output action codes
`define DSPWM_ACT_OFF 2'h0
`define DSPWM_ACT_TOGGLE 2'h1
`define DSPWM_ACT_NONINV 2'h2
`define DSPWM_ACT_INV 2'h3

// fixed top values and reset values
`define DSPWM_TOP_8BIT 16'h00FF
`define DSPWM_TOP_9BIT 16'h01FF
`define DSPWM_TOP_10BIT 16'h03FF
`define DSPWM_BOTTOM 16'h0000
`define DSPWM_RST_WORD 32'h0000_0000
`define DSPWM_RST_CAPTURE_TOP 16'hFFFF

`endif

// file: shared/dspwm_pkg.sv
/*
 * Types of the dual-slope PWM timer.
 * Assumes dspwm_cfg.svh on the include path.
 */
package dspwm_pkg;
`include "dspwm_cfg.svh"

   typedef enum logic [1:0] {
      DSPWM_SLOPE_UP = 2'b01,
      DSPWM_SLOPE_DOWN = 2'b10
   } dspwm_slope_t;

   typedef struct packed {
      logic dir_b;
      logic dir_a;
      logic [1:0] act_b;
      logic [1:0] act_a;
      logic [3:0] wsel;
   } dspwm_ctrl_t;

   typedef struct packed {
      logic capture;
      logic match_b;
      logic match_a;
      logic overflow;
   } dspwm_flags_t;

endpackage

// file: test/dspwm_timer_checker.sv
/*
 * Port-level assertions for the dual-slope PWM timer, bound to its top.
 * Assumes one clock domain and dspwm_cfg.svh on the include path.
 */
`timescale 1ns/1ps
`include "dspwm_cfg.svh"

module dspwm_timer_checker
#(
   parameter int CNT_W = 16
)
(
   input wire logic mclk_in, // clock
   input wire logic rst_n_in, // reset
   input wire logic timer_tick_in, // tick
   input wire logic psel_in, // select
   input wire logic penable_in, // enable
   input wire logic pwrite_in, // write
   input wire logic [11:0] paddr_in, // address
   input wire logic [31:0] pwdata_in, // write data
   input wire logic [31:0] prdata_out, // read data
   input wire logic pready_out, // ready
   input wire logic pslverr_out, // error
   input wire logic waveform_output_a_out, // wave a
   input wire logic waveform_output_a_oe_out, // enable a
   input wire logic waveform_output_b_out, // wave b
   input wire logic waveform_output_b_oe_out, // enable b
   input wire logic overflow_flag_out, // overflow
   input wire logic capture_flag_out // capture
);
   logic acc;
   logic clr_ovf;
   logic clr_cap;
   assign acc = psel_in && penable_in;
   assign clr_ovf = acc && pwrite_in && paddr_in == `DSPWM_OFS_FLAGS
      && pwdata_in[`DSPWM_FLG_OVERFLOW_BIT];
   assign clr_cap = acc && pwrite_in && paddr_in == `DSPWM_OFS_FLAGS
      && pwdata_in[`DSPWM_FLG_CAPTURE_BIT];
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_ctl_wr;
      acc && pwrite_in && paddr_in == `DSPWM_OFS_CONTROL;
   endsequence
   // idle ticks after a clear, so nothing may set the flag again
   sequence s_ovf_cleared;
      clr_ovf && !timer_tick_in ##1 !timer_tick_in [*3];
   endsequence
   ////////////////////////////////////////
   a_pin_dir_a: assert property (
      s_ctl_wr |=> waveform_output_a_oe_out == $past(pwdata_in[`DSPWM_CTL_DIR_A_BIT]))
      else $error("pin enable a does not follow control");
   a_pin_dir_b: assert property (
      s_ctl_wr |=> waveform_output_b_oe_out == $past(pwdata_in[`DSPWM_CTL_DIR_B_BIT]))
      else $error("pin enable b does not follow control");
   a_ovf_on_tick: assert property (
      $rose(overflow_flag_out) |-> $past(timer_tick_in))
      else $error("overflow set without tick");
   a_cap_on_tick: assert property (
      $rose(capture_flag_out) |-> $past(timer_tick_in))
      else $error("capture flag set without tick");
   a_wave_a_tick: assert property (
      $changed(waveform_output_a_out) |-> $past(timer_tick_in))
      else $error("wave a moved without tick");
   a_wave_b_tick: assert property (
      $changed(waveform_output_b_out) |-> $past(timer_tick_in))
      else $error("wave b moved without tick");
   a_ovf_sticky: assert property (
      $fell(overflow_flag_out) |-> $past(clr_ovf))
      else $error("overflow fell without clear");
   a_cap_sticky: assert property (
      $fell(capture_flag_out) |-> $past(clr_cap))
      else $error("capture flag fell without clear");
   a_ovf_clear_held: assert property (
      s_ovf_cleared |-> !overflow_flag_out)
      else $error("overflow not cleared");
   a_bad_addr_err: assert property (
      acc && paddr_in > `DSPWM_OFS_STATUS |-> pslverr_out)
      else $error("no error on unmapped address");
   a_bad_read_zero: assert property (
      acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_ready_high: assert property (pready_out)
      else $error("ready low");
endmodule

bind dspwm_timer dspwm_timer_checker #(.CNT_W(CNT_W)) u_checker (
   .mclk_in, .rst_n_in, .timer_tick_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .waveform_output_a_out,
   .waveform_output_a_oe_out, .waveform_output_b_out, .waveform_output_b_oe_out,
   .overflow_flag_out, .capture_flag_out
);

// file: test/tb.sv
/*
 * Self-checking bench of the dual-slope PWM timer over APB.
 * Assumes the package, dspwm_cfg.svh and the bound checker are compiled.
 */
`timescale 1ns/1ps
`include "dspwm_cfg.svh"

module tb import dspwm_pkg::*;;
   logic mclk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic timer_tick_in = 1'h0;
   logic psel_in = 1'h0;
   logic penable_in = 1'h0;
   logic pwrite_in = 1'h0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic waveform_output_a_out;
   logic waveform_output_a_oe_out;
   logic waveform_output_b_out;
   logic waveform_output_b_oe_out;
   logic overflow_flag_out;
   logic capture_flag_out;
   logic [31:0] rd;
   logic err;
   logic [15:0] top16;
   int fails = 0;
   int samples_checked = 0;

   dspwm_timer #(.CNT_W(16)) dut (
      .mclk_in, .rst_n_in, .timer_tick_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .waveform_output_a_out,
      .waveform_output_a_oe_out, .waveform_output_b_out, .waveform_output_b_oe_out,
      .overflow_flag_out, .capture_flag_out
   );

   initial
   begin
      forever #10 mclk_in = ~mclk_in;
   end
   ////////////////////////////////////////
   task test_done;
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // request held until ready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel_in <= 1'h1;
      penable_in <= 1'h0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'h1;
      // only the watchdog ends a wait that never sees ready
      do
      begin
         @(posedge mclk_in);
      end
      while (pready_out !== 1'h1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask

   task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask

   task run(input int n);
      @(posedge mclk_in);
      timer_tick_in <= 1'h1;
      repeat (n) @(posedge mclk_in);
      timer_tick_in <= 1'h0;
   endtask

   function automatic logic [31:0] ctl(input logic [3:0] s, input logic [1:0] aa,
      input logic [1:0] ab);
      dspwm_ctrl_t c;
      c = '{dir_b: 1'h1, dir_a: 1'h1, act_b: ab, act_a: aa, wsel: s};
      return {22'h00_0000, c};
   endfunction

   // count is pushed to just below top, then two ticks must turn it round
   task topchk(input logic [3:0] s, input logic [15:0] t);
      apb(1'h1, `DSPWM_OFS_CONTROL, ctl(s, 2'h0, 2'h0));
      apb(1'h1, `DSPWM_OFS_COUNT, 32'h0000_0000);
      run(1);
      apb(1'h1, `DSPWM_OFS_COUNT, {16'h0000, t - 16'h0001});
      run(2);
      rdchk("count past top", `DSPWM_OFS_COUNT, {16'h0000, t - 16'h0001});
      apb(1'h0, `DSPWM_OFS_STATUS, 32'h0000_0000);
      chk("down slope", 32'h0000_0001, {31'h0, rd[`DSPWM_STS_DOWN_BIT]});
      rdchk("count frozen", `DSPWM_OFS_COUNT, {16'h0000, t - 16'h0001});
   endtask

   // high samples over 84 ticks, a whole number of periods of every case
   // top is only rewritten while ticks are stopped
   task ent(input logic [3:0] s, input logic [15:0] t, input logic [15:0] a,
      input logic [15:0] b, input logic [1:0] aa, input logic [1:0] ab,
      input int ha, input int hb, input logic [3:0] fl);
      logic [31:0] na;
      logic [31:0] nb;
      na = 0;
      nb = 0;
      apb(1'h1, `DSPWM_OFS_CONTROL, ctl(4'h0, aa, ab));
      apb(1'h1, `DSPWM_OFS_COUNT, 32'h0000_0000);
      apb(1'h1, `DSPWM_OFS_COMPARE_A, {16'h0000, a});
      apb(1'h1, `DSPWM_OFS_COMPARE_B, {16'h0000, b});
      apb(1'h1, `DSPWM_OFS_CAPTURE_TOP, {16'h0000, t});
      apb(1'h1, `DSPWM_OFS_CONTROL, ctl(s, aa, ab));
      @(posedge mclk_in);
      timer_tick_in <= 1'h1;
      chk("pin enables", 32'h0000_0003,
         {30'h0, waveform_output_b_oe_out, waveform_output_a_oe_out});
      repeat (28) @(posedge mclk_in);
      repeat (84)
      begin
         @(posedge mclk_in);
         na += waveform_output_a_out;
         nb += waveform_output_b_out;
      end
      timer_tick_in <= 1'h0;
      if (ha >= 0)
         chk("high count a", ha, na);
      chk("high count b", hb, nb);
      rdchk("flags", `DSPWM_OFS_FLAGS, {28'h000_0000, fl});
      apb(1'h1, `DSPWM_OFS_FLAGS, 32'h0000_000F);
      rdchk("flags cleared", `DSPWM_OFS_FLAGS, 32'h0000_0000);
      chk("flag pins", 32'h0000_0000, {30'h0, capture_flag_out, overflow_flag_out});
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      rdchk("control", `DSPWM_OFS_CONTROL, 32'h0000_0000);
      rdchk("count", `DSPWM_OFS_COUNT, 32'h0000_0000);
      rdchk("capture top", `DSPWM_OFS_CAPTURE_TOP, 32'h0000_FFFF);
      rdchk("flags", `DSPWM_OFS_FLAGS, 32'h0000_0000);
      rdchk("status", `DSPWM_OFS_STATUS, 32'h0000_0000);
      apb(1'h1, 12'h01C, 32'hFFFF_FFFF);
      rdchk("unmapped data", 12'h01C, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      apb(1'h1, `DSPWM_OFS_CONTROL, ctl(4'h0, 2'h0, 2'h0));
      apb(1'h1, `DSPWM_OFS_COMPARE_A, 32'h0000_0003);
      apb(1'h1, `DSPWM_OFS_CAPTURE_TOP, 32'h0000_0003);
      topchk(4'hA, 16'h0003);
      topchk(4'hB, 16'h0003);
      topchk(4'h8, 16'h0003);
      topchk(4'h9, 16'h0003);
      for (int i = 1; i <= 3; i++)
      begin
         top16 = (16'h0080 << i) - 16'h0001;
         topchk(i[3:0], top16);
         apb(1'h1, `DSPWM_OFS_COMPARE_A, 32'hFFFF_FFFF);
         rdchk("masked compare", `DSPWM_OFS_COMPARE_A, {16'h0000, top16});
      end
      ent(4'hA, 16'h0007, 16'h0003, 16'h0003, 2'h2, 2'h3, 36, 48, 4'hF);
      ent(4'hA, 16'h0007, 16'h0000, 16'h0007, 2'h2, 2'h2, 0, 84, 4'hF);
      ent(4'hB, 16'h0007, 16'h0003, 16'h0001, 2'h1, 2'h2, 42, 28, 4'h7);
      ent(4'h8, 16'h0007, 16'h0005, 16'h0002, 2'h3, 2'h2, 24, 24, 4'hF);
      ent(4'hA, 16'h0007, 16'h0009, 16'h0003, 2'h2, 2'h3, -1, 48, 4'hD);
      // top from compare a lowered 5 -> 3 while running: old top turns, new top next
      apb(1'h1, `DSPWM_OFS_CONTROL, ctl(4'h0, 2'h0, 2'h0));
      apb(1'h1, `DSPWM_OFS_COMPARE_A, 32'h0000_0005);
      apb(1'h1, `DSPWM_OFS_CONTROL, ctl(4'hB, 2'h0, 2'h0));
      apb(1'h1, `DSPWM_OFS_COMPARE_A, 32'h0000_0003);
      apb(1'h1, `DSPWM_OFS_COUNT, 32'h0000_0000);
      run(1);
      apb(1'h1, `DSPWM_OFS_COUNT, 32'h0000_0004);
      run(2);
      rdchk("old top turn", `DSPWM_OFS_COUNT, 32'h0000_0004);
      run(8);
      rdchk("new top turn", `DSPWM_OFS_COUNT, 32'h0000_0002);
      test_done;
   end

   // the whole sequence needs about a thousand cycles
   initial
   begin
      repeat (20000) @(posedge mclk_in);
      fails++;
      test_done;
   end
endmodule
